// *** logic/msc_mode_ctrl.v ***
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Long hold over 1.5 s, switch on release.
// - Transmission mode: green steady, flashes when busy.
// - Configuration mode: red steady, flashes responding.
// - Red during self-test, then green transmission.
// - Hold serial input in 1000-byte buffer.
// - Blink green while buffer holds data.
// - Steady green only means data radiated.
// - Software switch only when enabled, default off.
// - Leave old mode, enter new, steady.
// - Any flashing condition wins over steady.
// - Busy while flashing, no mode detection; the code latches a request made while busy and switches once idle.
// - Transmission mode opens serial and radio.
// - Configuration mode gives register access, 9600.
// - All-ones own address transmits as broadcast.
// - All-ones own address receives everything.
// - Idle switch takes effect within 1 ms.
`include "msc_map.vh"
module msc_mode_ctrl #(
    parameter integer HOLD_CYCLES = `MSC_HOLD_US * `MSC_CLK_MHZ,
    parameter integer SWITCH_CYCLES = `MSC_SWITCH_US * `MSC_CLK_MHZ,
    parameter integer BLINK_CYCLES = `MSC_BLINK_US * `MSC_CLK_MHZ,
    parameter integer DEBOUNCE_CYCLES = `MSC_DEBOUNCE_US * `MSC_CLK_MHZ,
    parameter integer BUF_BYTES = `MSC_BUF_BYTES
) (
    input wire core_clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire button_n,
    input wire ser_byte_in,
    input wire radio_byte_taken,
    output reg led_green,
    output reg led_red,
    output reg cfg_mode,
    output reg serial_open,
    output reg radio_open,
    output reg reg_access_en,
    output reg tx_broadcast,
    output reg rx_accept_all,
    output reg buf_full
);
    // One-hot states of the mode switch sequence.
    localparam [4:0] ST_SELFTEST = 5'h01;
    localparam [4:0] ST_RUN = 5'h02;
    localparam [4:0] ST_LEAVE = 5'h04;
    localparam [4:0] ST_ENTER = 5'h08;
    localparam [4:0] ST_SETTLE = 5'h10;

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg mode_reg;
    reg pending_reg;
    reg selftest_done_reg;
    reg sw_en_reg;
    reg cmd_busy_reg;
    reg rx_busy_reg;
    reg [15:0] addr_reg;
    reg [10:0] level_reg;
    reg [31:0] blink_reg;
    reg blink_phase_reg;
    reg sw_req;
    wire pressed;
    wire long_release;
    wire busy;
    wire flashing;
    wire wr_en;
    wire rd_en;
    wire push;
    wire pop;
    wire own_bcast;

    msc_debounce #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .core_clk(core_clk),
        .resetn(resetn),
        .raw_n(button_n),
        .pressed(pressed)
    );

    msc_hold_timer #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_hold (
        .core_clk(core_clk),
        .resetn(resetn),
        .pressed(pressed),
        .long_release(long_release)
    );

    // Selects a decoded register address.
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Reports whether an address names one of the four registers.
    function mapped;
        input [11:0] a;
        begin
            mapped = hit(a, `MSC_OFF_CTRL) || hit(a, `MSC_OFF_STATUS)
                || hit(a, `MSC_OFF_ADDR) || hit(a, `MSC_OFF_BUF_LEVEL);
        end
    endfunction

    // Lights a lamp in its own mode, dark in the off half of a flash.
    function lamp;
        input owns;
        input flash;
        input phase;
        begin
            lamp = owns && !(flash && phase);
        end
    endfunction

    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;
    assign push = ser_byte_in && !mode_reg && (level_reg < BUF_BYTES);
    assign pop = radio_byte_taken && (level_reg != 11'h000);
    // pending data blinks; steady only means empty
    assign flashing = (!mode_reg && (level_reg != 11'h000 || rx_busy_reg))
        || (mode_reg && cmd_busy_reg);
    assign busy = flashing;
    assign own_bcast = (addr_reg == `MSC_ADDR_BCAST);

    // The switch bit is judged against the enable as it stood before this write.
    always @* begin
        sw_req = wr_en && hit(paddr, `MSC_OFF_CTRL) && pwdata[`MSC_CTRL_SW_SWITCH];
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_SELFTEST: begin
                if (selftest_done_reg)
                    state_next = ST_SETTLE;
            end
            ST_RUN: begin
                if (pending_reg && !busy)
                    state_next = ST_LEAVE;
            end
            ST_LEAVE: begin
                state_next = ST_ENTER;
            end
            ST_ENTER: begin
                state_next = ST_SETTLE;
            end
            ST_SETTLE: begin
                // The new mode is in force; the paths open next.
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_SELFTEST;
            end
        endcase
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_SELFTEST;
            mode_reg <= 1'b0;
            pending_reg <= 1'b0;
            selftest_done_reg <= 1'b0;
            sw_en_reg <= 1'b0;
            cmd_busy_reg <= 1'b0;
            rx_busy_reg <= 1'b0;
            addr_reg <= `MSC_ADDR_RESET;
            level_reg <= 11'h000;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_ENTER)
                mode_reg <= ~mode_reg;
            // latch request, set wins over clear
            if (long_release || (sw_req && sw_en_reg))
                pending_reg <= 1'b1;
            else if (state_reg == ST_LEAVE)
                pending_reg <= 1'b0;
            if (wr_en && hit(paddr, `MSC_OFF_CTRL)) begin
                selftest_done_reg <= selftest_done_reg | pwdata[`MSC_CTRL_SELFTEST_DONE];
                if (mode_reg)
                    sw_en_reg <= pwdata[`MSC_CTRL_SW_SWITCH_EN];
                cmd_busy_reg <= pwdata[`MSC_CTRL_CMD_BUSY];
                rx_busy_reg <= pwdata[`MSC_CTRL_RX_BUSY];
            end
            if (wr_en && hit(paddr, `MSC_OFF_ADDR))
                addr_reg <= pwdata[15:0];
            // A byte taken in while one leaves keeps the level unchanged.
            case ({push, pop})
                2'b10: level_reg <= level_reg + 11'h001;
                2'b01: level_reg <= level_reg - 11'h001;
                default: level_reg <= level_reg;
            endcase
        end
    end

    // Each flash opens with a lit half-period.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            blink_reg <= 32'h0000_0000;
            blink_phase_reg <= 1'b0;
        end else if (!flashing) begin
            blink_reg <= 32'h0000_0000;
            blink_phase_reg <= 1'b0;
        end else if (blink_reg >= BLINK_CYCLES - 1) begin
            blink_reg <= 32'h0000_0000;
            blink_phase_reg <= ~blink_phase_reg;
        end else begin
            blink_reg <= blink_reg + 32'h0000_0001;
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            led_green <= 1'b0;
            led_red <= 1'b1;
            cfg_mode <= 1'b0;
            serial_open <= 1'b0;
            radio_open <= 1'b0;
            reg_access_en <= 1'b0;
            tx_broadcast <= 1'b0;
            rx_accept_all <= 1'b0;
            buf_full <= 1'b0;
        end else begin
            cfg_mode <= mode_reg;
            // Full is flagged once the level reaches capacity.
            buf_full <= (level_reg >= BUF_BYTES);
            if (state_reg == ST_SELFTEST) begin
                led_red <= 1'b1;
                led_green <= 1'b0;
            end else if (state_reg == ST_LEAVE || state_reg == ST_ENTER) begin
                // old mode left before new entered
                led_red <= 1'b0;
                led_green <= 1'b0;
            end else begin
                led_green <= lamp(!mode_reg, flashing, blink_phase_reg);
                led_red <= lamp(mode_reg, flashing, blink_phase_reg);
            end
            serial_open <= (state_reg == ST_RUN);
            radio_open <= (state_reg == ST_RUN) && !mode_reg;
            reg_access_en <= (state_reg == ST_RUN) && mode_reg;
            tx_broadcast <= own_bcast;
            rx_accept_all <= own_bcast;
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Every transfer is answered in its first access cycle.
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
                pslverr <= !mapped(paddr);
            if (rd_en) begin
                if (hit(paddr, `MSC_OFF_CTRL))
                    prdata <= {27'h0000000, rx_busy_reg, cmd_busy_reg, 1'b0, sw_en_reg,
                        selftest_done_reg};
                else if (hit(paddr, `MSC_OFF_STATUS))
                    prdata <= {27'h0000000, own_bcast,
                        (state_reg == ST_RUN), pending_reg, busy, mode_reg};
                else if (hit(paddr, `MSC_OFF_ADDR))
                    prdata <= {16'h0000, addr_reg};
                else if (hit(paddr, `MSC_OFF_BUF_LEVEL))
                    prdata <= {21'h000000, level_reg};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end
endmodule // msc_mode_ctrl

// *** logic/msc_map.vh ***
`ifndef MSC_MAP_VH
`define MSC_MAP_VH
// Register byte offsets.
`define MSC_OFF_CTRL 12'h000
`define MSC_OFF_STATUS 12'h004
`define MSC_OFF_ADDR 12'h008
`define MSC_OFF_BUF_LEVEL 12'h00C
// Control register fields.
`define MSC_CTRL_SELFTEST_DONE 0
`define MSC_CTRL_SW_SWITCH_EN 1
`define MSC_CTRL_SW_SWITCH 2
`define MSC_CTRL_CMD_BUSY 3
`define MSC_CTRL_RX_BUSY 4
`define MSC_CTRL_RESET 32'h0000_0000
// Status register fields.
`define MSC_ST_CFG_MODE 0
`define MSC_ST_BUSY 1
`define MSC_ST_PENDING 2
`define MSC_ST_READY 3
`define MSC_ST_BCAST 4
// Own address reset value and broadcast value.
`define MSC_ADDR_RESET 16'h0000
`define MSC_ADDR_BCAST 16'hFFFF
// Timing, in microseconds, at 125 MHz.
`define MSC_CLK_MHZ 125
`define MSC_HOLD_US 1500000
`define MSC_DEBOUNCE_US 10
`define MSC_SWITCH_US 1000
`define MSC_BLINK_US 250000
`define MSC_BUF_BYTES 1000
`endif

// *** logic/msc_debounce.v ***
`timescale 1ns/1ps
// Synchronises the button and accepts a level only after it is stable.
module msc_debounce #(
    parameter integer STABLE_CYCLES = 1250
) (
    input wire core_clk,
    input wire resetn,
    input wire raw_n,
    output reg pressed
);
    reg sync1_reg;
    reg sync2_reg;
    reg [31:0] cnt_reg;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            cnt_reg <= 32'h0000_0000;
            pressed <= 1'b0;
        end else begin
            sync1_reg <= raw_n;
            sync2_reg <= sync1_reg;
            if (sync2_reg == pressed) begin
                if (cnt_reg >= STABLE_CYCLES - 1) begin
                    pressed <= ~sync2_reg;
                    cnt_reg <= 32'h0000_0000;
                end else begin
                    cnt_reg <= cnt_reg + 32'h0000_0001;
                end
            end else begin
                cnt_reg <= 32'h0000_0000;
            end
        end
    end
endmodule // msc_debounce

// *** logic/msc_hold_timer.v ***
`timescale 1ns/1ps
// Times a debounced press and pulses on release after a long hold.
module msc_hold_timer #(
    parameter integer HOLD_CYCLES = 187500000
) (
    input wire core_clk,
    input wire resetn,
    input wire pressed,
    output reg long_release
);
    reg [31:0] cnt_reg;
    reg long_reg;
    reg prev_reg;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 32'h0000_0000;
            long_reg <= 1'b0;
            prev_reg <= 1'b0;
            long_release <= 1'b0;
        end else begin
            prev_reg <= pressed;
            long_release <= 1'b0;
            if (pressed) begin
                if (cnt_reg > HOLD_CYCLES)
                    long_reg <= 1'b1;
                else
                    cnt_reg <= cnt_reg + 32'h0000_0001;
            end else begin
                cnt_reg <= 32'h0000_0000;
                long_reg <= 1'b0;
                // Short presses end here with no effect.
                if (prev_reg && long_reg)
                    long_release <= 1'b1;
            end
        end
    end
endmodule // msc_hold_timer

// *** verification/msc_monitor.sv ***
`timescale 1ns/1ps
module msc_monitor (
    input wire core_clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire led_green,
    input wire led_red,
    input wire cfg_mode,
    input wire radio_open,
    input wire reg_access_en,
    input wire tx_broadcast,
    input wire rx_accept_all
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    reg [2:0] off_cnt;
    // Cycles since both lamps were last dark, saturating.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            off_cnt <= 3'h7;
        end else if (!led_green && !led_red) begin
            off_cnt <= 3'h0;
        end else if (off_cnt != 3'h7) begin
            off_cnt <= off_cnt + 3'h1;
        end
    end
    property p_rdy_setup; psel && !penable |=> pready; endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("no ready");
    property p_rdy_acc; pready |-> psel && penable; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("stray ready");
    property p_unmap; psel && penable && pready && paddr > 12'h00C
        |-> pslverr && (pwrite || prdata == 32'h0); endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_bc_wr; psel && penable && pready && pwrite && paddr == 12'h008
        && pwdata[15:0] == 16'hFFFF |-> ##[1:3] tx_broadcast; endproperty
    a_bc_wr: assert property (p_bc_wr) else $error("bcast");
    property p_listen; $changed(rx_accept_all)
        |-> $past(psel && penable && pready && pwrite && paddr == 12'h008, 2); endproperty
    a_listen: assert property (p_listen) else $error("listen");
    property p_cfg_red; cfg_mode |-> !led_green; endproperty
    a_cfg_red: assert property (p_cfg_red) else $error("green in cfg");
    property p_cfg_rf; cfg_mode |-> !radio_open; endproperty
    a_cfg_rf: assert property (p_cfg_rf) else $error("radio in cfg");
    property p_acc; reg_access_en |-> cfg_mode; endproperty
    a_acc: assert property (p_acc) else $error("access in tx");
    property p_leave; $changed(cfg_mode) |-> off_cnt <= 3'h3; endproperty
    a_leave: assert property (p_leave) else $error("no leave");
    property p_tx_grn; !cfg_mode && led_green |-> !led_red; endproperty
    a_tx_grn: assert property (p_tx_grn) else $error("two lamps");
endmodule // msc_monitor
bind msc_mode_ctrl msc_monitor msc_monitor_i (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .led_green(led_green),
    .led_red(led_red), .cfg_mode(cfg_mode), .radio_open(radio_open),
    .reg_access_en(reg_access_en), .tx_broadcast(tx_broadcast),
    .rx_accept_all(rx_accept_all));

// *** verification/msc_host_model.sv ***
`timescale 1ns/1ps
module msc_host_model (
    input wire core_clk,
    input wire led_green,
    output reg ser_byte_in,
    output reg radio_byte_taken
);
    initial begin
        ser_byte_in = 1'b0;
        radio_byte_taken = 1'b0;
    end
    // each pulse is one 8N1 byte
    task send(input int n, output logic late);
        int i;
        int k;
        k = 0;
        while (led_green !== 1'b1 && k < 100) begin
            @(posedge core_clk);
            k++;
        end
        late = (led_green !== 1'b1);
        for (i = 0; i < n; i++) begin
            @(posedge core_clk);
            ser_byte_in <= 1'b1;
            @(posedge core_clk);
            ser_byte_in <= 1'b0;
        end
    endtask
    task drain(input int n, input int gap);
        int i;
        for (i = 0; i < n; i++) begin
            repeat (gap) @(posedge core_clk);
            radio_byte_taken <= 1'b1;
            @(posedge core_clk);
            radio_byte_taken <= 1'b0;
        end
    endtask
endmodule // msc_host_model

// *** verification/tb_msc_mode_ctrl.sv ***
`timescale 1ns/1ps
`include "msc_map.vh"
module tb_msc_mode_ctrl;
    reg core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, button_n = 1;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0;
    wire [31:0] prdata;
    wire pready, pslverr, ser_byte_in, radio_byte_taken, led_green, led_red, cfg_mode;
    wire serial_open, radio_open, reg_access_en, tx_broadcast, rx_accept_all, buf_full;
    int miscompares = 0, compares = 0, seed = 35, m_level = 0, n, t, i;
    logic [31:0] r, a;
    logic e;
    always #4 core_clk = ~core_clk;
    msc_mode_ctrl #(.HOLD_CYCLES(50), .SWITCH_CYCLES(10), .BLINK_CYCLES(8),
        .DEBOUNCE_CYCLES(4)) msc_mode_ctrl_i (.core_clk(core_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .button_n(button_n),
        .ser_byte_in(ser_byte_in), .radio_byte_taken(radio_byte_taken),
        .led_green(led_green), .led_red(led_red), .cfg_mode(cfg_mode),
        .serial_open(serial_open), .radio_open(radio_open), .reg_access_en(reg_access_en),
        .tx_broadcast(tx_broadcast), .rx_accept_all(rx_accept_all), .buf_full(buf_full));
    msc_host_model msc_host_model_i (.core_clk(core_clk), .led_green(led_green),
        .ser_byte_in(ser_byte_in), .radio_byte_taken(radio_byte_taken));
    task final_report;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task check(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            final_report;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_cfg(input int x);
        int k;
        k = 0;
        while (cfg_mode !== x[0] && k < 60) begin
            @(posedge core_clk);
            k++;
        end
        check(cfg_mode, x);
        if (k >= 60)
            final_report;
    endtask
    // Counts lamp transitions over five blink half-periods.
    task toggles(input logic g);
        logic p;
        int j;
        t = 0;
        p = g ? led_green : led_red;
        for (j = 0; j < 40; j++) begin
            @(posedge core_clk);
            if ((g ? led_green : led_red) !== p)
                t++;
            p = g ? led_green : led_red;
        end
    endtask
    task add_bytes(input int k);
        m_level = (m_level + k > `MSC_BUF_BYTES) ? `MSC_BUF_BYTES : m_level + k;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        check({led_red, led_green, cfg_mode}, 3'b100);
        apb(0, `MSC_OFF_CTRL, 0);
        check(r, `MSC_CTRL_RESET);
        apb(0, `MSC_OFF_ADDR, 0);
        check(r[15:0], `MSC_ADDR_RESET);
        apb(1, `MSC_OFF_CTRL, 32'h1);
        toggles(1);
        toggles(1);
        check({t[3:0], led_green, led_red}, 6'h02);
        check({serial_open, radio_open, reg_access_en}, 3'b110);
        apb(0, 12'h010, 0);
        check(e, 1);
        check(r, 0);
        $display("test power-up done");
        apb(1, `MSC_OFF_CTRL, 32'h7);
        toggles(1);
        check(cfg_mode, 0);
        for (i = 0; i < 2; i++) begin
            button_n <= 1'b0;
            repeat (i ? 90 : 20) @(posedge core_clk);
            check(cfg_mode, 0);
            button_n <= 1'b1;
            repeat (20) @(posedge core_clk);
        end
        wait_cfg(1);
        toggles(0);
        check({t[3:0], led_red, led_green}, 6'h02);
        check({radio_open, reg_access_en}, 2'b01);
        $display("test button done");
        // The enable must stand before the switch bit is written.
        apb(1, `MSC_OFF_CTRL, 32'h3);
        apb(1, `MSC_OFF_CTRL, 32'hF);
        toggles(0);
        check({t >= 2, cfg_mode}, 2'b11);
        apb(0, `MSC_OFF_STATUS, 0);
        check(r[`MSC_ST_PENDING], 1);
        apb(1, `MSC_OFF_CTRL, 32'h3);
        wait_cfg(0);
        $display("test command done");
        n = 1 + $unsigned($random(seed)) % 20;
        msc_host_model_i.send(n, e);
        check(e, 0);
        if (e)
            final_report;
        add_bytes(n);
        apb(0, `MSC_OFF_BUF_LEVEL, 0);
        check(r[10:0], m_level);
        apb(1, `MSC_OFF_CTRL, 32'h7);
        toggles(1);
        check({t >= 2, cfg_mode}, 2'b10);
        msc_host_model_i.drain(n, 3);
        m_level = 0;
        wait_cfg(1);
        apb(1, `MSC_OFF_CTRL, 32'h7);
        wait_cfg(0);
        $display("test buffer done");
        for (i = 0; i < 2; i++) begin
            a = i ? 32'hFFFF : ($random(seed) & 32'hFFFE);
            apb(1, `MSC_OFF_ADDR, a);
            apb(0, `MSC_OFF_ADDR, 0);
            check(r[15:0], a);
            check({tx_broadcast, rx_accept_all}, i ? 2'b11 : 2'b00);
        end
        msc_host_model_i.send(1001, e);
        check(e, 0);
        if (e)
            final_report;
        add_bytes(1001);
        apb(0, `MSC_OFF_BUF_LEVEL, 0);
        check({buf_full, r[10:0]}, {1'b1, m_level[10:0]});
        $display("test address and full done");
        final_report;
    end
endmodule // tb_msc_mode_ctrl
